/* File: core/acs_cfg.svh */
// What this block does
// - Resolution bits equal two times log2 of ratio plus log2 of count.
// - Ratio is a power of two 8..1024; count is 1, 2, 4 or 8.
// - Conversion lasts count times (ratio plus one) plus one sample cycles.
// - Any write to the five chain config registers resets gain stages.
// - Bias codes: 11 full, 10 three quarters, 01 half, 00 quarter.
// - Ready output goes low for exactly one sample cycle at end.
// - Serial register clock is at most 400 kHz; device copes with any rate.
// - Results are binary two's complement numbers.
// - Zero to two init cycles before, zero to five end cycles after.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Clock and sampling rates
`define ACS_CLK_HZ        20000000
`define ACS_FS_HZ         250000
`define ACS_FS_DIV        (`ACS_CLK_HZ / `ACS_FS_HZ)
`define ACS_SCL_MAX_HZ    400000
`define ACS_INIT_CYC      1
`define ACS_END_CYC       2
`define ACS_INIT_CYC_MAX  2
`define ACS_END_CYC_MAX   5

// Register byte offsets
`define ACS_OFF_CTRL      8'h00
`define ACS_OFF_STATUS    8'h04
`define ACS_OFF_RESULT    8'h08
`define ACS_OFF_ACQ1      8'h0c
`define ACS_OFF_ACQ2      8'h10
`define ACS_OFF_ACQ3      8'h14
`define ACS_OFF_ACQ4      8'h18
`define ACS_OFF_ACQ5      8'h1c
`define ACS_OFF_IRQ_STAT  8'h20
`define ACS_OFF_IRQ_CLR   8'h24
`define ACS_OFF_IRQ_EN    8'h28

// Field positions
`define ACS_CTRL_START    0
`define ACS_OSR_LSB       0
`define ACS_NEL_LSB       4
`define ACS_PGA_BIAS_LSB  0
`define ACS_ADC_BIAS_LSB  2
`define ACS_PGA_EN_LSB    0
`define ACS_CHAN_LSB      4
`define ACS_ST_BUSY       0
`define ACS_ST_SETTLED    1
`define ACS_ST_RES_LSB    8
`define ACS_IRQ_DONE      0
`define ACS_IRQ_SETTLED   1

// Reset values
`define ACS_RST_OSR       3'h0
`define ACS_RST_NEL       2'h0
`define ACS_RST_BIAS      2'h3
`define ACS_RST_PGA_EN    3'h0
`define ACS_RST_CHAN      3'h0
`define ACS_RST_GAIN      8'h00
`define ACS_RST_IRQ       2'h0

`endif

/* File: core/acs_pkg.sv */
package acs_pkg;

	// Conversion sequence states
	typedef enum logic [2:0] {
		ACS_IDLE,
		ACS_INIT,
		ACS_RUN,
		ACS_END,
		ACS_PULSE
	} acs_state_e;

	// Acquisition chain configuration as driven to the analog side
	typedef struct packed {
		logic [2:0] osr_code;     // log2(oversampling_ratio) - 3
		logic [1:0] nel_code;     // log2(elementary_conversion_count)
		logic [1:0] gain_stage_bias_sel;
		logic [1:0] converter_bias_sel;
		logic [2:0] gain_stage_en;
		logic [2:0] channel;
		logic [7:0] gain_word;
		logic [7:0] offset_word;
	} acs_cfg_s;

	// Bias current levels in quarters of nominal
	typedef struct packed {
		logic [2:0] gain_stage;
		logic [2:0] converter;
	} acs_bias_s;

endpackage

/* File: core/acs_sequencer.sv */
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "acs_cfg.svh"
// Conversion sequencer with Wishbone register file
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int FS_DIV   = `ACS_FS_DIV,
	parameter int INIT_CYC = `ACS_INIT_CYC,
	parameter int END_CYC  = `ACS_END_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [15:0] sample_data_i,
	output acs_cfg_s         cfg_o,
	output acs_bias_s        bias_o,
	output logic             gain_stage_reset_o,
	output logic      [4:0]  resolution_o,
	output logic             ready_n_o,
	output logic             irq_o
);
	localparam int CW = 14;

	// Effective resolution from the two codes
	function automatic logic [4:0] res_bits(input logic [2:0] oversampling_ratio,
	                                        input logic [1:0] nel);
		res_bits = 5'(({2'h0, oversampling_ratio} + 5'h03) * 5'h02) + {3'h0, nel};
	endfunction

	// Ratio value, always a power of two 8..1024
	function automatic logic [CW-1:0] osr_val(input logic [2:0] oversampling_ratio);
		osr_val = CW'(14'h0008 << oversampling_ratio);
	endfunction

	// Sample cycles of one conversion
	function automatic logic [CW-1:0] conv_len(input logic [2:0] oversampling_ratio,
	                                           input logic [1:0] nel);
		conv_len = CW'((osr_val(oversampling_ratio) + CW'(1)) << nel) + CW'(1);
	endfunction

	// Bias code to quarters of nominal current
	function automatic logic [2:0] bias_q(input logic [1:0] code);
		bias_q = {1'b0, code} + 3'h1;
	endfunction

	logic            fs_tick;
	logic            bus_req;
	logic            bus_wr;
	logic            acq_wr;
	logic            lane0;

	acs_cfg_s        cfg;
	acs_cfg_s        next_cfg;
	logic            ack;
	logic            next_ack;
	logic [31:0]     rdata;
	logic [31:0]     next_rdata;
	logic            start_pend;
	logic            next_start_pend;
	logic [1:0]      irq_stat;
	logic [1:0]      next_irq_stat;
	logic [1:0]      irq_en;
	logic [1:0]      next_irq_en;
	logic            gsr;
	logic            next_gsr;
	acs_bias_s       bias;
	acs_bias_s       next_bias;
	logic [4:0]      res;
	logic [4:0]      next_res;

	acs_state_e      state;
	acs_state_e      next_state;
	logic [CW-1:0]   cnt;
	logic [CW-1:0]   next_cnt;
	logic [15:0]     result;
	logic [15:0]     next_result;
	logic            ready_n;
	logic            next_ready_n;
	logic            done_ev;
	logic [CW-1:0]   settle_cnt;
	logic [CW-1:0]   next_settle_cnt;
	logic            settled;
	logic            settle_ev;

	acs_tick_div #(
		.DIV    (FS_DIV)
	) u_fs_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (fs_tick)
	);

	// Bus decode; write lands at the edge that samples ack high
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign bus_wr  = bus_req && wb_we_i && ack;
	assign lane0   = wb_sel_i[0];
	assign acq_wr  = bus_wr && lane0 &&
	                 (wb_adr_i == `ACS_OFF_ACQ1 ||
	                  wb_adr_i == `ACS_OFF_ACQ2 ||
	                  wb_adr_i == `ACS_OFF_ACQ3 ||
	                  wb_adr_i == `ACS_OFF_ACQ4 ||
	                  wb_adr_i == `ACS_OFF_ACQ5);

	// Settling tracker, only matters when a gain stage is in the path
	assign settled = (cfg.gain_stage_en == 3'h0) ||
	                 (settle_cnt >= osr_val(cfg.osr_code));

	// Settle counter restarts on any chain config write
	always_comb begin
		next_settle_cnt = settle_cnt;
		settle_ev       = 1'b0;
		if (acq_wr) begin
			next_settle_cnt = '0;
		end else if (fs_tick && settle_cnt < osr_val(cfg.osr_code)) begin
			next_settle_cnt = settle_cnt + CW'(1);
			settle_ev = (settle_cnt + CW'(1) == osr_val(cfg.osr_code)) &&
			            (cfg.gain_stage_en != 3'h0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_cnt <= '0;
		end else begin
			settle_cnt <= next_settle_cnt;
		end
	end

	// Register file and bus answer
	always_comb begin
		next_cfg        = cfg;
		next_irq_en     = irq_en;
		next_start_pend = start_pend;
		next_ack        = bus_req && !ack;
		next_rdata      = 32'h0000_0000;
		next_gsr        = acq_wr;
		next_irq_stat   = irq_stat;
		// Taken start clears first so a start written on a tick survives
		if (state == ACS_IDLE && fs_tick) begin
			next_start_pend = 1'b0;
		end
		if (bus_wr && lane0) begin
			case (wb_adr_i)
				`ACS_OFF_CTRL: begin
					if (wb_dat_i[`ACS_CTRL_START]) begin
						next_start_pend = 1'b1;
					end
				end
				`ACS_OFF_ACQ1: begin
					next_cfg.osr_code = wb_dat_i[`ACS_OSR_LSB +: 3];
					next_cfg.nel_code = wb_dat_i[`ACS_NEL_LSB +: 2];
				end
				`ACS_OFF_ACQ2: begin
					next_cfg.gain_stage_bias_sel =
						wb_dat_i[`ACS_PGA_BIAS_LSB +: 2];
					next_cfg.converter_bias_sel =
						wb_dat_i[`ACS_ADC_BIAS_LSB +: 2];
				end
				`ACS_OFF_ACQ3: begin
					next_cfg.gain_stage_en = wb_dat_i[`ACS_PGA_EN_LSB +: 3];
					next_cfg.channel       = wb_dat_i[`ACS_CHAN_LSB +: 3];
				end
				`ACS_OFF_ACQ4: next_cfg.gain_word   = wb_dat_i[7:0];
				`ACS_OFF_ACQ5: next_cfg.offset_word = wb_dat_i[7:0];
				`ACS_OFF_IRQ_CLR: begin
					next_irq_stat = irq_stat & ~wb_dat_i[1:0];
				end
				`ACS_OFF_IRQ_EN: next_irq_en = wb_dat_i[1:0];
				default: begin
				end
			endcase
		end
		// Set wins over a clear in the same cycle
		if (done_ev) begin
			next_irq_stat[`ACS_IRQ_DONE] = 1'b1;
		end
		if (settle_ev) begin
			next_irq_stat[`ACS_IRQ_SETTLED] = 1'b1;
		end
		if (bus_req && !ack && !wb_we_i) begin
			case (wb_adr_i)
				`ACS_OFF_STATUS: begin
					next_rdata[`ACS_ST_BUSY] =
						(state != ACS_IDLE) || start_pend;
					next_rdata[`ACS_ST_SETTLED] = settled;
					next_rdata[`ACS_ST_RES_LSB +: 5] = res;
				end
				`ACS_OFF_RESULT: begin
					next_rdata = {{16{result[15]}}, result};
				end
				`ACS_OFF_ACQ1: begin
					next_rdata[`ACS_OSR_LSB +: 3] = cfg.osr_code;
					next_rdata[`ACS_NEL_LSB +: 2] = cfg.nel_code;
				end
				`ACS_OFF_ACQ2: begin
					next_rdata[`ACS_PGA_BIAS_LSB +: 2] =
						cfg.gain_stage_bias_sel;
					next_rdata[`ACS_ADC_BIAS_LSB +: 2] =
						cfg.converter_bias_sel;
				end
				`ACS_OFF_ACQ3: begin
					next_rdata[`ACS_PGA_EN_LSB +: 3] = cfg.gain_stage_en;
					next_rdata[`ACS_CHAN_LSB +: 3]   = cfg.channel;
				end
				`ACS_OFF_ACQ4:     next_rdata[7:0] = cfg.gain_word;
				`ACS_OFF_ACQ5:     next_rdata[7:0] = cfg.offset_word;
				`ACS_OFF_IRQ_STAT: next_rdata[1:0] = irq_stat;
				`ACS_OFF_IRQ_EN:   next_rdata[1:0] = irq_en;
				default:           next_rdata = 32'h0000_0000;
			endcase
		end
		next_bias.gain_stage = bias_q(next_cfg.gain_stage_bias_sel);
		next_bias.converter  = bias_q(next_cfg.converter_bias_sel);
		next_res = res_bits(next_cfg.osr_code, next_cfg.nel_code);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg.osr_code            <= `ACS_RST_OSR;
			cfg.nel_code            <= `ACS_RST_NEL;
			cfg.gain_stage_bias_sel <= `ACS_RST_BIAS;
			cfg.converter_bias_sel  <= `ACS_RST_BIAS;
			cfg.gain_stage_en       <= `ACS_RST_PGA_EN;
			cfg.channel             <= `ACS_RST_CHAN;
			cfg.gain_word           <= `ACS_RST_GAIN;
			cfg.offset_word         <= `ACS_RST_GAIN;
			irq_en                  <= `ACS_RST_IRQ;
			irq_stat                <= `ACS_RST_IRQ;
			start_pend              <= 1'b0;
			ack                     <= 1'b0;
			rdata                   <= 32'h0000_0000;
			gsr                     <= 1'b0;
			bias.gain_stage         <= bias_q(`ACS_RST_BIAS);
			bias.converter          <= bias_q(`ACS_RST_BIAS);
			res                     <= res_bits(`ACS_RST_OSR, `ACS_RST_NEL);
		end else begin
			cfg        <= next_cfg;
			irq_en     <= next_irq_en;
			irq_stat   <= next_irq_stat;
			start_pend <= next_start_pend;
			ack        <= next_ack;
			rdata      <= next_rdata;
			gsr        <= next_gsr;
			bias       <= next_bias;
			res        <= next_res;
		end
	end

	// Conversion sequence, advanced on sampling ticks
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_result  = result;
		next_ready_n = ready_n;
		done_ev      = 1'b0;
		if (fs_tick) begin
			case (state)
				ACS_IDLE: begin
					next_ready_n = 1'b1;
					if (start_pend) begin
						if (INIT_CYC > 0) begin
							next_state = ACS_INIT;
							next_cnt   = CW'(INIT_CYC - 1);
						end else begin
							next_state = ACS_RUN;
							next_cnt   = conv_len(cfg.osr_code,
							                      cfg.nel_code) - CW'(1);
						end
					end
				end
				ACS_INIT: begin
					next_cnt = cnt - CW'(1);
					if (cnt == '0) begin
						next_state = ACS_RUN;
						next_cnt   = conv_len(cfg.osr_code,
						                      cfg.nel_code) - CW'(1);
					end
				end
				ACS_RUN: begin
					next_cnt = cnt - CW'(1);
					if (cnt == '0) begin
						next_result = sample_data_i;
						if (END_CYC > 0) begin
							next_state = ACS_END;
							next_cnt   = CW'(END_CYC - 1);
						end else begin
							next_state   = ACS_PULSE;
							next_ready_n = 1'b0;
							done_ev      = 1'b1;
						end
					end
				end
				ACS_END: begin
					next_cnt = cnt - CW'(1);
					if (cnt == '0) begin
						next_state   = ACS_PULSE;
						next_ready_n = 1'b0;
						done_ev      = 1'b1;
					end
				end
				ACS_PULSE: begin
					next_state   = ACS_IDLE;
					next_ready_n = 1'b1;
				end
				default: begin
					next_state   = ACS_IDLE;
					next_ready_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state   <= ACS_IDLE;
			cnt     <= '0;
			result  <= 16'h0000;
			ready_n <= 1'b1;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			result  <= next_result;
			ready_n <= next_ready_n;
		end
	end

	// Outputs; one-cycle bus answer is far inside any 400 kHz frame
	assign wb_ack_o           = ack;
	assign wb_dat_o           = rdata;
	assign cfg_o              = cfg;
	assign bias_o             = bias;
	assign resolution_o       = res;
	assign gain_stage_reset_o = gsr;
	assign ready_n_o          = ready_n;
	assign irq_o              = |(irq_stat & irq_en);
endmodule

/* File: core/acs_tick_div.sv */
`timescale 1ns/1ns
// Sampling clock enable: one-cycle pulse every DIV clocks
module acs_tick_div #(
	parameter int DIV = 80
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	localparam int W = $clog2(DIV + 1);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tick;

	// Count down and fire on wrap
	always_comb begin
		next_tick = 1'b0;
		next_cnt  = cnt - W'(1);
		if (cnt == '0) begin
			next_cnt  = W'(DIV - 1);
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule

/* File: tb/acs_conv_model.sv */
`timescale 1ns/1ns
// Converter side: presents a signed sample code
module acs_conv_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] code_i,
	output logic      [15:0] sample_o
);
	// Two's complement code held towards the sampler
	always_ff @(posedge clk_i) begin
		sample_o <= code_i;
	end
endmodule

/* File: tb/acs_sequencer_sva.sv */
`timescale 1ns/1ns
// Port checker for the sequencer
module acs_sequencer_sva
	import acs_pkg::*;
#(
	parameter int FS_DIV = 4
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] sample_data_i,
	input wire acs_cfg_s    cfg_o,
	input wire acs_bias_s   bias_o,
	input wire logic        gain_stage_reset_o,
	input wire logic [4:0]  resolution_o,
	input wire logic        ready_n_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [11:0] low_cnt;
	logic [11:0] next_low_cnt;
	logic        acq_wr;
	// Length of the current low phase of ready
	always_comb begin
		next_low_cnt = (rst_i || ready_n_o) ? 12'h0 : low_cnt + 12'h1;
	end
	always_ff @(posedge clk_i) begin
		low_cnt <= next_low_cnt;
	end
	// Completed write to a chain config register
	assign acq_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
		&& wb_adr_i inside {8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
	property p_ready_width;
		$rose(ready_n_o) |-> low_cnt == FS_DIV;
	endproperty
	a_ready_width: assert property (p_ready_width)
		else $error("ready low phase not one sample period");
	property p_ready_max;
		low_cnt <= FS_DIV;
	endproperty
	a_ready_max: assert property (p_ready_max)
		else $error("ready held low too long");
	property p_ready_idle;
		$fell(rst_i) |-> ready_n_o && !gain_stage_reset_o && !wb_ack_o;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("outputs not idle after reset");
	property p_res;
		$stable(cfg_o) [*2] |-> resolution_o == ({1'b0, cfg_o.osr_code, 1'b0}
			+ 5'h6 + {3'h0, cfg_o.nel_code});
	endproperty
	a_res: assert property (p_res)
		else $error("resolution does not match ratio and count");
	property p_bias_g;
		$stable(cfg_o) [*2] |->
			bias_o.gain_stage == {1'b0, cfg_o.gain_stage_bias_sel} + 3'h1;
	endproperty
	a_bias_g: assert property (p_bias_g)
		else $error("gain stage bias level wrong");
	property p_bias_c;
		$stable(cfg_o) [*2] |->
			bias_o.converter == {1'b0, cfg_o.converter_bias_sel} + 3'h1;
	endproperty
	a_bias_c: assert property (p_bias_c)
		else $error("converter bias level wrong");
	property p_gsr_set;
		acq_wr |=> gain_stage_reset_o ##1 !gain_stage_reset_o;
	endproperty
	a_gsr_set: assert property (p_gsr_set)
		else $error("no gain stage reset after config write");
	property p_gsr_cause;
		gain_stage_reset_o |-> $past(acq_wr);
	endproperty
	a_gsr_cause: assert property (p_gsr_cause)
		else $error("gain stage reset without config write");
	c_ready: cover property ($fell(ready_n_o));
	c_gsr: cover property (gain_stage_reset_o);
	c_irq: cover property (irq_o);
endmodule
bind acs_sequencer acs_sequencer_sva #(.FS_DIV(FS_DIV)) u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sample_data_i(sample_data_i), .cfg_o(cfg_o), .bias_o(bias_o),
	.gain_stage_reset_o(gain_stage_reset_o), .resolution_o(resolution_o),
	.ready_n_o(ready_n_o), .irq_o(irq_o));

/* File: tb/tb_acs_sequencer.sv */
`timescale 1ns/1ns
`include "acs_cfg.svh"
module tb_acs_sequencer;
	import acs_pkg::*;
	localparam int FS = 4;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, gsr;
	logic        rdy_n, irq;
	logic [7:0]  adr = 0;
	logic [31:0] wdat = 0, rd, rdat;
	logic [15:0] code = 0, smp;
	logic [4:0]  res;
	acs_cfg_s    cfg;
	acs_bias_s   bias;
	int          error_cnt = 0, n_tests = 0, gsr_cnt = 0;

	// Clock and reset-pulse tally
	always #25 clk = ~clk;
	always @(posedge clk) if (gsr === 1'b1) gsr_cnt++;

	acs_sequencer #(.FS_DIV(FS)) dut (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
		.sample_data_i(smp), .cfg_o(cfg), .bias_o(bias),
		.gain_stage_reset_o(gsr), .resolution_o(res), .ready_n_o(rdy_n),
		.irq_o(irq));
	acs_conv_model u_conv (.clk_i(clk), .code_i(code), .sample_o(smp));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single Wishbone cycle, then one idle cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		while (ack !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) error_cnt++;
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task t_reset;
		chk({27'h0, res}, 32'h6);
		chk({31'h0, rdy_n}, 32'h1);
		chk({26'h0, bias}, 32'h24);
		wb(1'b0, 8'h04, 32'h0);
		chk({27'h0, rdat[12:8]}, 32'h6);
		wb(1'b0, 8'h3c, 32'h0);
		chk(rdat, 32'h0);
	endtask

	task t_res;
		int g;
		for (int c = 0; c < 8; c++) begin
			g = gsr_cnt;
			wb(1'b1, 8'h0c, {26'h0, 2'(c % 4), 1'b0, 3'(c)});
			repeat (2) @(posedge clk);
			chk({27'h0, res}, 32'(2 * (c + 3) + c % 4));
			chk(32'(gsr_cnt - g), 32'h1);
		end
	endtask

	task t_bias;
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, 8'h10, {28'h0, 2'(c), 2'(c)});
			repeat (2) @(posedge clk);
			chk({26'h0, bias}, {26'h0, 3'(c + 1), 3'(c + 1)});
		end
	endtask

	// Settle, start, time the conversion, read and clear
	task t_conv(input logic [2:0] en, input logic [1:0] nel,
		input logic [15:0] v);
		int n;
		int len;
		len = `ACS_INIT_CYC + (1 << nel) * 9 + 1 + `ACS_END_CYC;
		code <= v;
		wb(1'b1, 8'h0c, {26'h0, nel, 4'h0});
		wb(1'b1, 8'h14, {29'h0, en});
		wb(1'b1, 8'h18, 32'h5a);
		wb(1'b1, 8'h1c, 32'ha5);
		wb(1'b0, 8'h04, 32'h0);
		chk({31'h0, rdat[1]}, {31'h0, en == 3'h0});
		repeat (10 * FS) @(posedge clk);
		wb(1'b0, 8'h04, 32'h0);
		chk({31'h0, rdat[1]}, 32'h1);
		wb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rdat[1]}, {31'h0, en != 3'h0});
		chk({24'h0, cfg.gain_word}, 32'h5a);
		chk({24'h0, cfg.offset_word}, 32'ha5);
		chk({29'h0, cfg.gain_stage_en}, {29'h0, en});
		wb(1'b1, 8'h28, 32'h1);
		wb(1'b1, 8'h24, 32'h3);
		wb(1'b1, 8'h00, 32'h1);
		n = 0;
		while (rdy_n !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, n > len * FS && n <= len * FS + FS}, 1);
		chk({31'h0, irq}, 32'h1);
		n = 0;
		while (rdy_n === 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'(FS));
		wb(1'b0, 8'h08, 32'h0);
		chk(rdat, {{16{v[15]}}, v});
		wb(1'b1, 8'h28, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rdat[0]}, 32'h1);
		wb(1'b1, 8'h24, 32'h1);
		wb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rdat[0]}, 32'h0);
	endtask

	task finish_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_res;
		t_bias;
		t_conv(3'h1, 2'h0, 16'h8001);
		t_conv(3'h0, 2'h1, 16'h1234);
		finish_test;
	end
endmodule
